// ---- shared/sudb_pkg.sv ----
// Purpose: shared constants and types of the serial data buffer and clock gate
// Assumes: 40 MHz peripheral clock, four channels in two units
// Notes: channel i belongs to unit i/2; only channel 0 holds 9-bit data
package sudb_pkg;
   localparam int NCH = 4;
   localparam int SR_W = 9;
   localparam int DIV_LSB = 9;
   localparam int DIV_W = 7;
   localparam int GATE_U0_BIT = 2;
   localparam int GATE_U1_BIT = 3;
   localparam int NINE_BIT_CH = 0;
   localparam logic [31:0] GATE_ADDR = 32'h40020420;
   // channel buffers sit on consecutive halfwords from this base
   localparam logic [31:0] BUF_BASE = 32'h40041100;
   localparam logic [7:0] GATE_RST = 8'h00;
   localparam logic [15:0] BUF_RST = 16'h0000;
   localparam logic [1:0] LEN_SEL_7 = 2'h2;
   localparam logic [1:0] LEN_SEL_8 = 2'h3;
   localparam logic [1:0] LEN_SEL_9 = 2'h1;
   localparam logic [3:0] LEN_7 = 4'h7;
   localparam logic [3:0] LEN_8 = 4'h8;
   localparam logic [3:0] LEN_9 = 4'h9;

   typedef struct packed {
      logic channel_running_flag;
      logic [1:0] data_length_sel;
      logic transfer_clock_source_sel;
   } sudb_chan_ctl_s;

   typedef struct packed {
      logic sclk;
      logic sdi;
   } sudb_pin_in_s;

   typedef enum logic {
      SUDB_IDLE = 1'b0,
      SUDB_SHIFT = 1'b1
   } sudb_state_e;
endpackage

// ---- core/sudb_top.sv ----
// Purpose: data buffers, shift registers and clock gate of the serial unit
// Assumes: cpu accesses take one cycle; read data appears one cycle later
// Notes: lsb-first shifting only; transfer starts on a buffer write while running
// Behaviour
// - nine-bit shift register per channel
// - shift register reached only via buffer
// - received word to buffer, written word shifted
// - sixteen-bit buffer, high seven bits divider
// - data right-justified by configured length
// - sixteen-bit reads and writes accepted
// - low byte also reachable by byte access
// - buffer resets to zero
// - nine-bit length only on first channel
// - stopped byte write clears high seven bits
// - bits above length up to bit 8 read zero after receive
// - gate register byte wide, resets zero
// - gate off holds unit in reset
// - gate off ignores writes, reads initial
// - internal transfer clock divides by high bits plus one
`timescale 1ns/1ps
module sudb_top
   import sudb_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [31:0] cpu_addr_in,
   input wire logic [15:0] cpu_wdata_in,
   input wire logic cpu_wr_in,
   input wire logic cpu_rd_in,
   input wire logic cpu_word_in,
   output logic [15:0] cpu_rdata_out,
   output logic [1:0] serial_unit_clock_on_out,
   input wire sudb_chan_ctl_s [NCH-1:0] ctl_in,
   input wire sudb_pin_in_s [NCH-1:0] pin_in,
   output logic [NCH-1:0] sdo_out,
   output logic [NCH-1:0] rx_done_out
);

   logic [7:0] peripheral_clock_gate;
   logic [NCH-1:0][15:0] channel_data_buffer;
   logic [1:0] unit_on;
   logic [15:0] next_rdata;
   logic [1:0] rd_ch;

   function automatic logic buf_hit(input logic [31:0] a);
      buf_hit = (a[31:3] == BUF_BASE[31:3]) && !a[0];
   endfunction

   // channel of a buffer address; one halfword slot per channel
   function automatic logic [1:0] buf_chan(input logic [31:0] a);
      buf_chan = a[2:1];
   endfunction

   function automatic logic gate_hit(input logic [31:0] a);
      gate_hit = (a == GATE_ADDR);
   endfunction

   function automatic logic [3:0] len_of(input logic [1:0] sel, input int ch);
      unique case (sel)
         LEN_SEL_7: len_of = LEN_7;
         LEN_SEL_8: len_of = LEN_8;
         LEN_SEL_9: len_of = (ch == NINE_BIT_CH) ? LEN_9 : LEN_8;
         default: len_of = LEN_8;
      endcase
   endfunction

   // right-justify the shifted-in word and zero bits above the length
   function automatic logic [SR_W-1:0] align(input logic [SR_W-1:0] w, input logic [3:0] len);
      logic [SR_W-1:0] sh;
      logic [SR_W-1:0] m;
      sh = '0;
      m = '0;
      sh = w >> (4'(SR_W) - len);
      for (int b = 0; b < SR_W; b++) begin
         m[b] = b < int'(len);
      end
      align = sh & m;
   endfunction

   assign unit_on = {peripheral_clock_gate[GATE_U1_BIT], peripheral_clock_gate[GATE_U0_BIT]};
   assign serial_unit_clock_on_out = unit_on;

   // gate register takes byte writes only
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         peripheral_clock_gate <= GATE_RST;
      end else if (cpu_wr_in && !cpu_word_in && gate_hit(cpu_addr_in)) begin
         peripheral_clock_gate <= cpu_wdata_in[7:0];
      end
   end

   assign rd_ch = buf_chan(cpu_addr_in);

   // gated units and unmapped addresses read as zero
   always_comb begin
      next_rdata = BUF_RST;
      if (gate_hit(cpu_addr_in)) begin
         next_rdata = {8'h00, peripheral_clock_gate};
      end else if (buf_hit(cpu_addr_in) && unit_on[rd_ch[1]]) begin
         if (cpu_word_in) begin
            next_rdata = channel_data_buffer[rd_ch];
         end else begin
            next_rdata = {8'h00, channel_data_buffer[rd_ch][7:0]};
         end
      end else begin
         next_rdata = BUF_RST;
      end
   end

   // read data holds until the next read strobe
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cpu_rdata_out <= '0;
      end else if (cpu_rd_in) begin
         cpu_rdata_out <= next_rdata;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         sudb_state_e state;
         logic [SR_W-1:0] shreg;
         logic [3:0] bit_cnt;
         logic [DIV_W-1:0] div_cnt;
         logic sclk_prev;
         logic on;
         logic wr_hit;
         logic start;
         logic tick;
         logic last;
         logic [3:0] len;
         logic [SR_W-1:0] next_shreg;
         logic [SR_W-1:0] wr_low;
         logic ext_edge;
         logic div_match;

         assign on = unit_on[gi / 2];
         assign len = len_of(ctl_in[gi].data_length_sel, gi);
         assign wr_hit = cpu_wr_in && on && buf_hit(cpu_addr_in) && buf_chan(cpu_addr_in) == 2'(gi);
         assign start = wr_hit && ctl_in[gi].channel_running_flag && state == SUDB_IDLE;
         // 8-bit channels have no bit 8 storage
         assign wr_low = {(gi == NINE_BIT_CH) && cpu_word_in && cpu_wdata_in[8], cpu_wdata_in[7:0]};
         // external clock counts rising edges; internal divides by high bits plus one
         assign ext_edge = pin_in[gi].sclk && !sclk_prev;
         assign div_match = div_cnt == channel_data_buffer[gi][15:DIV_LSB];
         always_comb begin
            tick = 1'b0;
            if (state == SUDB_SHIFT) begin
               tick = ctl_in[gi].transfer_clock_source_sel ? ext_edge : div_match;
            end
         end
         assign last = tick && (bit_cnt == len - 4'h1);
         assign next_shreg = {pin_in[gi].sdi, shreg[SR_W-1:1]};
         assign sdo_out[gi] = shreg[0];

         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               sclk_prev <= 1'b0;
            end else begin
               sclk_prev <= on && pin_in[gi].sclk;
            end
         end

         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               div_cnt <= '0;
            end else if (!on || start || tick) begin
               div_cnt <= '0;
            end else if (state == SUDB_SHIFT) begin
               div_cnt <= div_cnt + 7'h01;
            end
         end

         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               state <= SUDB_IDLE;
            end else if (!on || !ctl_in[gi].channel_running_flag) begin
               state <= SUDB_IDLE;
            end else if (start) begin
               state <= SUDB_SHIFT;
            end else if (last) begin
               state <= SUDB_IDLE;
            end
         end

         // shift register is loaded only from a buffer write
         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               shreg <= '0;
            end else if (!on) begin
               shreg <= '0;
            end else if (!ctl_in[gi].channel_running_flag) begin
               shreg <= shreg;
            end else if (start) begin
               shreg <= wr_low;
            end else if (tick) begin
               shreg <= next_shreg;
            end
         end

         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               bit_cnt <= 4'h0;
            end else if (!on || !ctl_in[gi].channel_running_flag || start) begin
               bit_cnt <= 4'h0;
            end else if (tick) begin
               bit_cnt <= bit_cnt + 4'h1;
            end
         end

         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               rx_done_out[gi] <= 1'b0;
            end else begin
               rx_done_out[gi] <= on && ctl_in[gi].channel_running_flag && last;
            end
         end

         // divide field; a byte write while stopped clears it
         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               channel_data_buffer[gi][15:DIV_LSB] <= BUF_RST[15:DIV_LSB];
            end else if (!on) begin
               channel_data_buffer[gi][15:DIV_LSB] <= BUF_RST[15:DIV_LSB];
            end else if (wr_hit && cpu_word_in) begin
               channel_data_buffer[gi][15:DIV_LSB] <= cpu_wdata_in[15:DIV_LSB];
            end else if (wr_hit && !ctl_in[gi].channel_running_flag) begin
               channel_data_buffer[gi][15:DIV_LSB] <= '0;
            end
         end

         // received word wins the low bits over a same-cycle cpu write
         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               channel_data_buffer[gi][SR_W-1:0] <= BUF_RST[SR_W-1:0];
            end else if (!on) begin
               channel_data_buffer[gi][SR_W-1:0] <= BUF_RST[SR_W-1:0];
            end else if (ctl_in[gi].channel_running_flag && last) begin
               channel_data_buffer[gi][SR_W-1:0] <= align(next_shreg, len);
            end else if (wr_hit && cpu_word_in) begin
               channel_data_buffer[gi][SR_W-1:0] <= wr_low;
            end else if (wr_hit) begin
               channel_data_buffer[gi][7:0] <= cpu_wdata_in[7:0];
            end
         end
      end
   endgenerate

endmodule

// ---- dv/sudb_chk.sv ----
// Purpose: port checks of the serial data buffer and clock gate
// Assumes: one cpu access per strobe, read data one cycle later
// Notes: sees only the top ports, bound below
`timescale 1ns/1ps
module sudb_chk
   import sudb_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [31:0] cpu_addr_in,
   input wire logic [15:0] cpu_wdata_in,
   input wire logic cpu_wr_in,
   input wire logic cpu_rd_in,
   input wire logic cpu_word_in,
   input wire logic [15:0] cpu_rdata_out,
   input wire logic [1:0] serial_unit_clock_on_out,
   input wire logic [NCH-1:0] sdo_out,
   input wire logic [NCH-1:0] rx_done_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   wire [1:0] g = serial_unit_clock_on_out;
   wire [15:0] q = cpu_rdata_out;
   wire gw = cpu_wr_in && cpu_addr_in == GATE_ADDR;
   property p_rst; $rose(rst_n_in) |-> g == 2'h0 && q == 16'h0; endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear after reset");
   property p_gwr; gw && !cpu_word_in |=> g == $past(cpu_wdata_in[3:2]); endproperty
   a_gwr: assert property (p_gwr) else $error("gate byte write lost");
   property p_gwd; gw && cpu_word_in |=> $stable(g); endproperty
   a_gwd: assert property (p_gwd) else $error("gate took a word write");
   property p_off; !g[0] && !$past(g[0]) |-> sdo_out[1:0] == 2'h0 && rx_done_out[1:0] == 2'h0; endproperty
   a_off: assert property (p_off) else $error("gated unit not held");
   property p_roff; cpu_rd_in && cpu_addr_in == BUF_BASE && !g[0] |=> q == 16'h0; endproperty
   a_roff: assert property (p_roff) else $error("gated buffer read not zero");
   property p_hold; !cpu_rd_in |=> $stable(q); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_b8; cpu_rd_in && cpu_word_in && cpu_addr_in == BUF_BASE + 32'h2 |=> !q[8]; endproperty
   a_b8: assert property (p_b8) else $error("bit eight set off channel zero");
   property p_pul; rx_done_out[0] |=> !rx_done_out[0]; endproperty
   a_pul: assert property (p_pul) else $error("receive pulse too long");
   c_rx0: cover property (rx_done_out[0]);
   c_rx1: cover property (rx_done_out[1]);
   c_gw: cover property (gw && !cpu_word_in);
endmodule
bind sudb_top sudb_chk u_chk (.mclk_in, .rst_n_in, .cpu_addr_in, .cpu_wdata_in, .cpu_wr_in, .cpu_rd_in,
   .cpu_word_in, .cpu_rdata_out, .serial_unit_clock_on_out, .sdo_out, .rx_done_out);

// ---- dv/sudb_peer.sv ----
// Purpose: serial peer clocking one channel from outside
// Assumes: one bit per sclk rise, lsb first
// Notes: gap_in slows the peer; sclk stands low between frames
`timescale 1ns/1ps
module sudb_peer
   import sudb_pkg::*;
(
   input wire logic mclk_in,
   input wire logic go_in,
   input wire logic [8:0] tx_in,
   input wire logic [3:0] len_in,
   input wire logic [1:0] gap_in,
   input wire logic sdo_in,
   output sudb_pin_in_s pin_out,
   output logic [8:0] got_out
);
   initial pin_out = '0;
   always @(posedge go_in) begin
      got_out = 9'h0;
      for (int i = 0; i < len_in; i++) begin
         @(negedge mclk_in) pin_out = '{1'b0, tx_in[i]};
         repeat (gap_in) @(negedge mclk_in);
         @(negedge mclk_in) pin_out.sclk = 1'b1;
         got_out[i] = sdo_in;
      end
      // released line shows the inverse so a stale bit cannot pass
      @(negedge mclk_in) pin_out = '{1'b0, !pin_out.sdi};
   end
endmodule

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench of the serial data buffer and clock gate
// Assumes: cpu strobes one cycle wide, driven on falling edges
// Notes: channel 1 clocked by the peer, channel 0 by its divider
`timescale 1ns/1ps
module tb_top;
   import sudb_pkg::*;
   logic mclk_in = 0, rst_n_in = 0, wr = 0, rd = 0, wd = 0, go = 0;
   logic [31:0] ad = 0;
   logic [15:0] wdt = 0, q, v;
   logic [1:0] uc, gap = 0;
   logic [8:0] got;
   logic [3:0] len = 0;
   logic [NCH-1:0] sdo, rxd;
   sudb_chan_ctl_s [NCH-1:0] ctl = '0;
   sudb_pin_in_s p1;
   int n_fail = 0, n_tests = 0, k;
   always #12.5 mclk_in = !mclk_in;
   sudb_top u_dut (.mclk_in, .rst_n_in, .cpu_addr_in(ad), .cpu_wdata_in(wdt), .cpu_wr_in(wr), .cpu_rd_in(rd),
      .cpu_word_in(wd), .cpu_rdata_out(q), .serial_unit_clock_on_out(uc), .ctl_in(ctl),
      .pin_in({4'h0, p1, 2'h1}), .sdo_out(sdo), .rx_done_out(rxd));
   sudb_peer u_peer (.mclk_in, .go_in(go), .tx_in(9'h1ff), .len_in(len), .gap_in(gap), .sdo_in(sdo[1]),
      .pin_out(p1), .got_out(got));
   task chk(string nm, logic [15:0] s, logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task acc(logic w, logic [31:0] a, logic [15:0] d, logic bw);
      @(negedge mclk_in) {wr, rd, ad, wdt, wd} = {w, !w, a, d, bw};
      @(negedge mclk_in) {wr, rd} = 2'h0;
      v = q;
   endtask
   task rc(string nm, logic [31:0] a, logic bw, logic [15:0] e);
      acc(0, a, 16'h0, bw);
      chk(nm, bw ? v : {8'h0, v[7:0]}, e);
   endtask
   task results;
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge mclk_in);
      n_fail++;
      results;
   end
   initial begin
      repeat (4) @(negedge mclk_in);
      rst_n_in = 1;
      acc(1, BUF_BASE, 16'h1234, 1);
      acc(1, GATE_ADDR, 16'h000c, 1);
      rc("gate", GATE_ADDR, 0, 16'h0);
      acc(1, GATE_ADDR, 16'h000c, 0);
      rc("gate", GATE_ADDR, 0, 16'h0c);
      chk("unit on", {14'h0, uc}, 16'h3);
      rc("buf0", BUF_BASE, 1, 16'h0);
      $display("test gate done");
      acc(1, BUF_BASE, 16'hfffe, 1);
      rc("buf0", BUF_BASE, 1, 16'hfffe);
      acc(1, BUF_BASE + 2, 16'hffff, 1);
      rc("buf1", BUF_BASE + 2, 1, 16'hfeff);
      acc(1, BUF_BASE, 16'h5a, 0);
      acc(0, BUF_BASE, 16'h0, 1);
      chk("buf0 byte", v & 16'hfeff, 16'h005a);
      rc("alias", BUF_BASE, 0, 16'h5a);
      acc(1, BUF_BASE + 4, 16'h1234, 1);
      rc("buf2", BUF_BASE + 4, 1, 16'h1234);
      rc("odd", BUF_BASE + 1, 1, 16'h0);
      $display("test access done");
      for (k = 0; k < 3; k++) begin
         ctl[1] = '{1'b1, k == 0 ? LEN_SEL_7 : k == 1 ? LEN_SEL_8 : LEN_SEL_9, 1'b1};
         len = k == 0 ? LEN_7 : LEN_8;
         gap = k[1:0];
         acc(1, BUF_BASE + 2, 16'h00a5, 1);
         go = 1;
         for (int j = 0; j < 80 && rxd[1] !== 1'b1; j++) @(negedge mclk_in);
         go = 0;
         chk("rx done", {15'h0, rxd[1]}, 16'h1);
         rc("buf1 rx", BUF_BASE + 2, 1, (16'h1 << len) - 16'h1);
         chk("peer", {7'h0, got}, 16'h00a5 & ((16'h1 << len) - 16'h1));
      end
      $display("test link done");
      ctl[0] = '{1'b1, LEN_SEL_9, 1'b0};
      acc(1, BUF_BASE, 16'h0355, 1);
      for (k = 0; k < 40 && rxd[0] !== 1'b1; k++) @(negedge mclk_in);
      // nine ticks at divide two, then the pulse
      chk("ticks", k[15:0], 16'h12);
      rc("buf0 rx", BUF_BASE, 1, 16'h03ff);
      $display("test divider done");
      acc(1, GATE_ADDR, 16'h04, 0);
      rc("buf2 off", BUF_BASE + 4, 1, 16'h0);
      acc(1, GATE_ADDR, 16'h00, 0);
      acc(1, GATE_ADDR, 16'h0c, 0);
      rc("buf0 reset", BUF_BASE, 1, 16'h0);
      $display("test gate off done");
      results;
   end
endmodule
